// ---- design/prs_pkg.sv ----
// Purpose: Shared constants for the receive status signalling block
// Assumes: Core clock of 125 MHz
// Notes: Mode and speed codes are strap or core driven
package prs_pkg;
   // Core clock
   localparam int PRS_CLK_PERIOD_NS = 8;
   // Receive clock periods per speed
   localparam int PRS_RXC_PERIOD_NS_1000 = 8;
   localparam int PRS_RXC_PERIOD_NS_100 = 40;
   localparam int PRS_RXC_PERIOD_NS_10 = 400;
   localparam int PRS_RXC_CYC_1000 = PRS_RXC_PERIOD_NS_1000 / PRS_CLK_PERIOD_NS;
   localparam int PRS_RXC_CYC_100 = PRS_RXC_PERIOD_NS_100 / PRS_CLK_PERIOD_NS;
   localparam int PRS_RXC_CYC_10 = PRS_RXC_PERIOD_NS_10 / PRS_CLK_PERIOD_NS;
   localparam int PRS_CNT_W = 6;
   // Cycles counted in the strap state before the address straps are caught
   localparam int PRS_STRAP_CYC = 4;
   localparam int PRS_STRAP_W = 3;
   // Buffer word layout
   localparam int PRS_NIB_W = 4;
   localparam int PRS_WORD_W = 7;
   localparam int PRS_F_DATA_LSB = 0;
   localparam int PRS_F_VALID = 4;
   localparam int PRS_F_ERR = 5;
   localparam int PRS_F_EXT = 6;
   localparam int PRS_BUF_DEPTH = 2;
   localparam logic [2:0] PRS_ADDR_RST = 3'h0;

   typedef enum logic [1:0] {
      PRS_IF_GMII = 2'b00,
      PRS_IF_RGMII = 2'b01,
      PRS_IF_MII = 2'b10
   } prs_if_t;

   typedef enum logic [1:0] {
      PRS_SPD_10 = 2'b00,
      PRS_SPD_100 = 2'b01,
      PRS_SPD_1000 = 2'b10
   } prs_speed_t;

   typedef enum logic [1:0] {
      PRS_ST_RESET = 2'b00,
      PRS_ST_STRAP = 2'b01,
      PRS_ST_RUN = 2'b10
   } prs_state_t;
endpackage

// ---- design/prs_buf.sv ----
// Purpose: Small valid/ready buffer in the receive nibble path
// Assumes: Single clock, clock enable freezes all state
// Notes: Depth must be a power of two
`timescale 1ns/1ns
`default_nettype none
module prs_buf #(
   parameter int WIDTH = 7,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Fill side
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   // Drain side
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;

   wire [AW:0] fill_level = wr_ptr_reg - rd_ptr_reg;
   // Full when the pointers are one whole depth apart
   wire full = (fill_level == (AW+1)'(DEPTH));
   wire empty = (wr_ptr_reg == rd_ptr_reg);
   wire push = i_valid && !full && i_ce;
   wire pop = i_ready && !empty && i_ce;

   assign o_ready = !full;
   assign o_valid = !empty;
   assign o_data = mem_reg[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= i_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
         end
      end
   end
endmodule
`default_nettype wire

// ---- design/prs_rx_status.sv ----
// Purpose: Receive data and status pins of the transceiver toward the MAC
// Assumes: Core receive stream on i_clk; transmit activity from another domain
// Notes: Error, carrier and collision pins carry address straps during reset
//
// Summary of operation
// - Low receive nibble is driven toward the MAC in GMII, RGMII and MII.
// - GMII gigabit: error pin high for data error or carrier extension.
// - 10 or 100 speed, GMII or MII: error pin high only for data error.
// - Carrier sense high while transmitting or receiving, GMII and MII.
// - Full duplex: collision held low always.
// - Error, carrier, collision pins double as address bits two, one, zero.
// - Receive clock per speed; data, valid, error launched at its rising edge.
`timescale 1ns/1ns
`default_nettype none
module prs_rx_status
   import prs_pkg::*;
#(
   parameter int BUF_DEPTH = PRS_BUF_DEPTH
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   // Operating mode from the core
   input wire logic [1:0] i_if_mode,
   input wire logic [1:0] i_speed,
   input wire logic i_full_duplex,
   // Transmit activity, foreign domain
   input wire logic i_tx_active,
   // Receive stream from the core
   input wire logic i_rx_carrier,
   input wire logic i_up_valid,
   output logic o_up_ready,
   input wire logic [3:0] i_up_data,
   input wire logic i_up_err,
   input wire logic i_up_ext,
   // Receive pins toward the MAC
   output logic o_rx_clk,
   output logic o_rx_launch,
   output logic [3:0] o_rxd,
   output logic o_rx_dv,
   output logic o_rx_ctl_rise,
   output logic o_rx_ctl_fall,
   // Shared error / address bit two pin
   input wire logic i_rx_er,
   output logic o_rx_er,
   output logic o_rx_er_oe,
   // Shared carrier / address bit one pin
   input wire logic i_crs,
   output logic o_crs,
   output logic o_crs_oe,
   // Shared collision / address bit zero pin
   input wire logic i_col,
   output logic o_col,
   output logic o_col_oe,
   // Caught address straps
   output logic o_phys_addr_bit_two,
   output logic o_phys_addr_bit_one,
   output logic o_phys_addr_bit_zero,
   output logic o_addr_valid
);
   // Reset release
   logic [1:0] rst_sync_reg;
   wire rst_n = rst_sync_reg[1];

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   // Three-stage samplers for foreign inputs: tx activity and the three pins
   logic [3:0] s1_reg;
   logic [3:0] s2_reg;
   logic [3:0] s3_reg;
   logic [3:0] in_reg;
   logic [3:0] in_reg_next;
   wire [3:0] raw_in = {i_tx_active, i_rx_er, i_crs, i_col};

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= 4'h0;
         s2_reg <= 4'h0;
         s3_reg <= 4'h0;
         in_reg <= 4'h0;
      end else if (i_ce) begin
         s1_reg <= raw_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         in_reg <= in_reg_next;
      end
   end

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         in_reg_next[k] = (s2_reg[k] == s3_reg[k]) ? s3_reg[k] : in_reg[k];
      end
   end
   wire tx_act = in_reg[3];

   // Strap phase: pins released, then address bits caught once
   prs_state_t state_reg;
   prs_state_t state_next;
   logic [PRS_STRAP_W-1:0] strap_cnt_reg;
   logic [2:0] addr_reg;
   wire strap_done = (strap_cnt_reg == PRS_STRAP_W'(PRS_STRAP_CYC));

   always_comb begin
      unique case (state_reg)
         PRS_ST_RESET: state_next = PRS_ST_STRAP;
         PRS_ST_STRAP: state_next = strap_done ? PRS_ST_RUN : PRS_ST_STRAP;
         PRS_ST_RUN: state_next = PRS_ST_RUN;
         default: state_next = PRS_ST_RESET;
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= PRS_ST_RESET;
         strap_cnt_reg <= '0;
         addr_reg <= PRS_ADDR_RST;
      end else if (i_ce) begin
         state_reg <= state_next;
         if (state_reg == PRS_ST_STRAP && !strap_done) begin
            strap_cnt_reg <= strap_cnt_reg + PRS_STRAP_W'(1);
         end
         if (state_reg == PRS_ST_STRAP && strap_done) begin
            addr_reg <= in_reg[2:0];
         end
      end
   end

   wire run = (state_reg == PRS_ST_RUN);
   assign o_phys_addr_bit_two = addr_reg[2];
   assign o_phys_addr_bit_one = addr_reg[1];
   assign o_phys_addr_bit_zero = addr_reg[0];
   assign o_addr_valid = run;

   // Mode decode
   wire mode_rgmii = (i_if_mode == PRS_IF_RGMII);
   wire mode_gmii = (i_if_mode == PRS_IF_GMII);
   wire mode_mii = (i_if_mode == PRS_IF_MII);
   wire spd_giga = (i_speed == PRS_SPD_1000);

   // Receive clock divider
   logic [PRS_CNT_W-1:0] period;
   always_comb begin
      unique case (i_speed)
         PRS_SPD_1000: period = PRS_CNT_W'(PRS_RXC_CYC_1000);
         PRS_SPD_100: period = PRS_CNT_W'(PRS_RXC_CYC_100);
         default: period = PRS_CNT_W'(PRS_RXC_CYC_10);
      endcase
   end

   logic [PRS_CNT_W-1:0] rxc_cnt_reg;
   logic rx_clk_reg;
   wire launch = run && (rxc_cnt_reg >= period - PRS_CNT_W'(1));
   wire [PRS_CNT_W-1:0] rxc_cnt_next = launch ? '0 : rxc_cnt_reg + PRS_CNT_W'(1);
   wire [PRS_CNT_W-1:0] high_cyc = (period + PRS_CNT_W'(1)) >> 1;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxc_cnt_reg <= '0;
         rx_clk_reg <= 1'b0;
      end else if (i_ce && run) begin
         rxc_cnt_reg <= rxc_cnt_next;
         rx_clk_reg <= (rxc_cnt_next < high_cyc);
      end
   end
   assign o_rx_clk = rx_clk_reg;
   assign o_rx_launch = launch && i_ce;

   // Nibble buffer, drained one word per receive clock rise
   wire [PRS_WORD_W-1:0] up_word = {i_up_ext, i_up_err, i_up_valid, i_up_data};
   wire [PRS_WORD_W-1:0] buf_word;
   wire buf_valid;
   wire up_push = i_up_valid || i_up_ext || i_up_err;

   prs_buf #(
      .WIDTH(PRS_WORD_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_ce(i_ce),
      .i_valid(up_push && run),
      .o_ready(o_up_ready),
      .i_data(up_word),
      .o_valid(buf_valid),
      .i_ready(launch),
      .o_data(buf_word)
   );

   wire take = launch && buf_valid;
   wire w_dv = take && buf_word[PRS_F_VALID];
   wire w_err = take && buf_word[PRS_F_ERR];
   wire w_ext = take && buf_word[PRS_F_EXT];
   wire [3:0] w_data = take ? buf_word[PRS_F_DATA_LSB +: PRS_NIB_W] : 4'h0;
   // Extension counts only at gigabit; below it only an error during valid data
   wire er_giga = w_err || (w_ext && !w_dv);
   wire er_low = w_err && w_dv;
   wire er_next = spd_giga ? er_giga : er_low;

   logic [3:0] rxd_reg;
   logic dv_reg;
   logic er_reg;
   logic ctl_fall_reg;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxd_reg <= 4'h0;
         dv_reg <= 1'b0;
         er_reg <= 1'b0;
         ctl_fall_reg <= 1'b0;
      end else if (i_ce && launch) begin
         rxd_reg <= w_data;
         dv_reg <= w_dv;
         er_reg <= er_next;
         ctl_fall_reg <= w_dv ^ er_next;
      end
   end

   assign o_rxd = rxd_reg;
   assign o_rx_dv = dv_reg;
   assign o_rx_ctl_rise = dv_reg;
   assign o_rx_ctl_fall = ctl_fall_reg;

   // Status pins, driven only once the straps are caught
   logic crs_reg;
   logic col_reg;
   wire crs_next = tx_act || i_rx_carrier;
   wire col_next = !i_full_duplex && tx_act && i_rx_carrier;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         crs_reg <= 1'b0;
         col_reg <= 1'b0;
      end else if (i_ce) begin
         crs_reg <= crs_next;
         col_reg <= col_next;
      end
   end

   wire gm = mode_gmii || mode_mii;
   assign o_rx_er = er_reg && !mode_rgmii;
   assign o_rx_er_oe = run && gm;
   assign o_crs = crs_reg;
   assign o_crs_oe = run && gm;
   assign o_col = col_reg && !i_full_duplex;
   assign o_col_oe = run && gm;
endmodule
`default_nettype wire

// ---- tb/prs_rx_status_chk.sv ----
// Purpose: Port assertions for the receive status block
// Assumes: One core clock domain
// Notes: Bound to the top module
`timescale 1ns/1ns
`default_nettype none
module prs_rx_status_chk
   import prs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [1:0] i_if_mode,
   input wire logic [1:0] i_speed,
   input wire logic i_full_duplex,
   input wire logic i_rx_carrier,
   input wire logic i_rx_er,
   input wire logic o_rx_clk,
   input wire logic o_rx_launch,
   input wire logic [3:0] o_rxd,
   input wire logic o_rx_dv,
   input wire logic o_rx_er,
   input wire logic o_rx_er_oe,
   input wire logic o_rx_ctl_rise,
   input wire logic o_crs,
   input wire logic o_crs_oe,
   input wire logic o_col,
   input wire logic o_col_oe,
   input wire logic o_phys_addr_bit_two,
   input wire logic o_phys_addr_bit_one,
   input wire logic o_phys_addr_bit_zero,
   input wire logic o_addr_valid
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   hold_outs_a: assert property (!$past(o_rx_launch) |-> $stable({o_rxd, o_rx_dv, o_rx_er}))
      else $error("receive pins changed without launch");
   rise_launch_a: assert property ($rose(o_rx_clk) && $past(o_addr_valid) |-> $past(o_rx_launch))
      else $error("receive clock rose without launch");
   giga_clk_a: assert property (i_speed == PRS_SPD_1000 && $past(i_speed) == PRS_SPD_1000
      && $past(o_addr_valid) |-> o_rx_clk)
      else $error("gigabit receive clock not high");
   col_full_a: assert property (i_full_duplex |-> !o_col)
      else $error("collision in full duplex");
   col_half_a: assert property (o_col |-> $past(i_rx_carrier) && !$past(i_full_duplex))
      else $error("collision without reception");
   crs_rx_a: assert property ($past(i_rx_carrier) && $past(o_crs_oe) && o_crs_oe |-> o_crs)
      else $error("carrier sense low while receiving");
   rgmii_er_a: assert property (i_if_mode == PRS_IF_RGMII && $past(i_if_mode) == PRS_IF_RGMII
      |-> !o_rx_er && !o_rx_er_oe)
      else $error("error pin used in RGMII");
   ctl_rise_a: assert property (o_rx_ctl_rise == o_rx_dv)
      else $error("rising control differs from valid");
   er_slow_a: assert property (o_rx_er && i_speed != PRS_SPD_1000 && $stable(i_speed) |-> o_rx_dv)
      else $error("slow speed error without valid");
   oe_strap_a: assert property (!o_addr_valid |-> !o_rx_er_oe && !o_crs_oe && !o_col_oe)
      else $error("shared pin driven before straps");
   strap_hold_a: assert property (o_addr_valid && $past(o_addr_valid)
      |-> $stable({o_phys_addr_bit_two, o_phys_addr_bit_one, o_phys_addr_bit_zero}))
      else $error("address straps changed");
   strap_catch_a: assert property ($rose(o_addr_valid) |-> o_phys_addr_bit_two == $past(i_rx_er, 2))
      else $error("address bit two not from pin");
endmodule
bind prs_rx_status prs_rx_status_chk u_chk (.i_clk, .i_resetn, .i_if_mode, .i_speed, .i_full_duplex,
   .i_rx_carrier, .i_rx_er, .o_rx_clk, .o_rx_launch, .o_rxd, .o_rx_dv, .o_rx_er, .o_rx_er_oe,
   .o_rx_ctl_rise, .o_crs, .o_crs_oe, .o_col, .o_col_oe, .o_phys_addr_bit_two, .o_phys_addr_bit_one,
   .o_phys_addr_bit_zero, .o_addr_valid);
`default_nettype wire

// ---- tb/prs_mac_model.sv ----
// Purpose: Receiving controller model with strap resistors
// Assumes: Pins read one cycle after each launch
// Notes: Released shared pins rest at their strap level
`timescale 1ns/1ns
`default_nettype none
module prs_mac_model #(
   parameter logic [2:0] STRAP = 3'h5
) (
   input wire logic i_clk,
   input wire logic i_launch,
   input wire logic [3:0] i_rxd,
   input wire logic i_dv,
   input wire logic i_er,
   input wire logic i_fall,
   input wire logic i_er_oe,
   input wire logic i_crs,
   input wire logic i_crs_oe,
   input wire logic i_col,
   input wire logic i_col_oe,
   output logic o_er_pin,
   output logic o_crs_pin,
   output logic o_col_pin
);
   logic launch_d = 1'b0;
   logic [6:0] cap_q[$];
   assign o_er_pin = i_er_oe ? i_er : STRAP[2];
   assign o_crs_pin = i_crs_oe ? i_crs : STRAP[1];
   assign o_col_pin = i_col_oe ? i_col : STRAP[0];
   always @(posedge i_clk) begin
      launch_d <= i_launch;
      if (launch_d && (i_dv || i_er || i_fall)) begin
         cap_q.push_back({i_fall, i_er, i_dv, i_rxd});
      end
   end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the receive status block
// Assumes: Inputs driven at the falling clock edge
// Notes: Straps 3'h5 held by the controller model
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import prs_pkg::*;
   logic i_clk = 0, i_resetn = 0, i_ce = 1, i_full_duplex = 0, i_tx_active = 0, i_rx_carrier = 0;
   logic i_up_valid = 0, i_up_err = 0, i_up_ext = 0, full_seen = 0;
   logic [1:0] i_if_mode = PRS_IF_GMII, i_speed = PRS_SPD_1000;
   logic [3:0] i_up_data = 4'h0, o_rxd;
   logic o_up_ready, o_rx_clk, o_rx_launch, o_rx_dv, o_rx_ctl_fall, i_rx_er, o_rx_er, o_rx_er_oe;
   logic i_crs, o_crs, o_crs_oe, i_col, o_col, o_col_oe, a2, a1, a0, o_addr_valid;
   int error_cnt = 0, comparisons = 0;
   always #4 i_clk = ~i_clk;
   prs_rx_status u_dut (.i_clk, .i_resetn, .i_ce, .i_if_mode, .i_speed, .i_full_duplex, .i_tx_active,
      .i_rx_carrier, .i_up_valid, .o_up_ready, .i_up_data, .i_up_err, .i_up_ext, .o_rx_clk, .o_rx_launch,
      .o_rxd, .o_rx_dv, .o_rx_ctl_rise(), .o_rx_ctl_fall, .i_rx_er, .o_rx_er, .o_rx_er_oe, .i_crs, .o_crs,
      .o_crs_oe, .i_col, .o_col, .o_col_oe, .o_phys_addr_bit_two(a2), .o_phys_addr_bit_one(a1),
      .o_phys_addr_bit_zero(a0), .o_addr_valid);
   prs_mac_model u_mac (.i_clk, .i_launch(o_rx_launch), .i_rxd(o_rxd), .i_dv(o_rx_dv), .i_er(o_rx_er),
      .i_fall(o_rx_ctl_fall), .i_er_oe(o_rx_er_oe), .i_crs(o_crs), .i_crs_oe(o_crs_oe), .i_col(o_col),
      .i_col_oe(o_col_oe), .o_er_pin(i_rx_er), .o_crs_pin(i_crs), .o_col_pin(i_col));
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [6:0] exp, input logic [6:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic waitfor(input int cnt);
      int n;
      n = 0;
      while (u_mac.cap_q.size() < cnt && o_addr_valid !== 1'b0) begin
         @(negedge i_clk);
         n++;
         if (n > 2000) begin
            error_cnt++;
            print_verdict();
         end
      end
   endtask
   task automatic push(input logic v, input logic e, input logic x, input logic [3:0] d);
      int n;
      n = 0;
      {i_up_valid, i_up_err, i_up_ext, i_up_data} = {v, e, x, d};
      while (o_up_ready !== 1'b1) begin
         full_seen = 1;
         @(negedge i_clk);
         n++;
         if (n > 500) begin
            error_cnt++;
            print_verdict();
         end
      end
      @(negedge i_clk);
   endtask
   task automatic expect_caps(input logic [6:0] exp[$], input logic [6:0] m);
      {i_up_valid, i_up_err, i_up_ext, i_up_data} = 7'h0;
      waitfor(exp.size());
      cyc(120);
      chk("word count", 7'(exp.size()), 7'(u_mac.cap_q.size()));
      foreach (exp[i]) chk("captured word", exp[i] & m, u_mac.cap_q[i] & m);
      u_mac.cap_q.delete();
   endtask
   task automatic t_strap();
      int n;
      n = 0;
      while (o_addr_valid !== 1'b1 && n < 100) begin
         @(negedge i_clk);
         n++;
      end
      chk("address straps", 7'h5, {4'h0, a2, a1, a0});
      chk("pin enables", 7'h7, {4'h0, o_rx_er_oe, o_crs_oe, o_col_oe});
      $display("test strap done");
   endtask
   task automatic t_giga();
      push(1, 0, 0, 4'ha);
      push(1, 1, 0, 4'h5);
      push(0, 0, 1, 4'h0);
      push(1, 0, 1, 4'h3);
      expect_caps('{7'h1a, 7'h35, 7'h20, 7'h13}, 7'h3f);
      $display("test gigabit done");
   endtask
   task automatic t_slow();
      full_seen = 0;
      cyc(10);
      push(1, 0, 0, 4'h1);
      push(1, 0, 0, 4'h2);
      push(1, 1, 0, 4'h3);
      push(0, 1, 0, 4'h4);
      push(0, 0, 1, 4'h6);
      chk("buffer refused", 7'h1, {6'h0, full_seen});
      expect_caps('{7'h11, 7'h12, 7'h33}, 7'h3f);
      $display("test slow done");
   endtask
   task automatic t_status();
      i_rx_carrier = 1;
      cyc(8);
      chk("carrier rx", 7'h2, {5'h0, o_crs, o_col});
      i_tx_active = 1;
      cyc(8);
      chk("collision half", 7'h3, {5'h0, o_crs, o_col});
      i_full_duplex = 1;
      cyc(8);
      chk("collision full", 7'h2, {5'h0, o_crs, o_col});
      i_rx_carrier = 0;
      cyc(8);
      chk("carrier tx", 7'h2, {5'h0, o_crs, o_col});
      i_tx_active = 0;
      i_full_duplex = 0;
      cyc(8);
      chk("carrier idle", 7'h0, {5'h0, o_crs, o_col});
      $display("test status done");
   endtask
   task automatic t_rgmii();
      cyc(10);
      push(1, 1, 0, 4'h9);
      push(1, 0, 0, 4'h4);
      chk("error pin enable", 7'h0, {6'h0, o_rx_er_oe});
      expect_caps('{7'h19, 7'h54}, 7'h7f);
      $display("test rgmii done");
   endtask
   initial begin
      cyc(10);
      i_resetn = 1;
      t_strap();
      t_giga();
      i_if_mode = PRS_IF_MII;
      i_speed = PRS_SPD_10;
      t_slow();
      t_status();
      i_if_mode = PRS_IF_RGMII;
      i_speed = PRS_SPD_100;
      t_rgmii();
      print_verdict();
   end
endmodule
`default_nettype wire
